/* rtl/ubsel_consts.vh */
// constants for the utility bus select and fast reset block
`ifndef UBSEL_CONSTS_VH
`define UBSEL_CONSTS_VH

// register offsets on the plain register port
`define UBSEL_FRAC_OFFSET 8'h92
`define UBSEL_DEC_EN_OFFSET 8'h4E
`define UBSEL_STATUS_OFFSET 8'h4F

// fast reset / a20 control fields
`define UBSEL_FRAC_RST_BIT 0
`define UBSEL_FRAC_A20_BIT 1
`define UBSEL_FRAC_RESET 2'h0

// decode enable fields
`define UBSEL_EN_RTC 0
`define UBSEL_EN_KBD 1
`define UBSEL_EN_FLOPPY 2
`define UBSEL_EN_IDE 3
`define UBSEL_EN_SERA 4
`define UBSEL_EN_SERB 5
`define UBSEL_EN_PAR 6
`define UBSEL_EN_FLOPPY_SEC 7
`define UBSEL_DEC_EN_RESET 8'h7F

// status fields
`define UBSEL_ST_FLOPPY_PRESENT 0
`define UBSEL_ST_RST_BUSY 1
`define UBSEL_ST_GROUP 2
`define UBSEL_ST_ALE_BUSY 3

// timing counts in isa bus clock periods
`define UBSEL_RST_PULSE_CLKS 4
`define UBSEL_ALE_HOLD_CLKS 2

// io addresses
`define UBSEL_IO_RTC_IDX 10'h070
`define UBSEL_IO_RTC_DATA 10'h071
`define UBSEL_IO_KBD_DATA 10'h060
`define UBSEL_IO_KBD_CMD 10'h064
`define UBSEL_IO_FLP_PRI 10'h3F0
`define UBSEL_IO_FLP_SEC 10'h370
`define UBSEL_IO_FLP_STAT_PRI 10'h3F7
`define UBSEL_IO_FLP_STAT_SEC 10'h377
`define UBSEL_IO_IDE_BASE 10'h1F0
`define UBSEL_IO_SERA 10'h3F8
`define UBSEL_IO_SERB 10'h2F8
`define UBSEL_IO_PAR 10'h378

// peripheral codes, decoder one (group select low)
`define UBSEL_CODE_RTC_ALE 3'h0
`define UBSEL_CODE_KBD 3'h1
`define UBSEL_CODE_FLOPPY 3'h2
`define UBSEL_CODE_IDE 3'h3
`define UBSEL_CODE_SERA 3'h4
`define UBSEL_CODE_SERB 3'h5
`define UBSEL_CODE_PAR 3'h6
// peripheral codes, decoder two (group select high)
`define UBSEL_CODE_RTC_DATA 3'h1
`define UBSEL_CODE_IDLE 3'h7

`endif

/* rtl/ubsel_isa_pulse.v */
// pulse stretcher counting sampled isa bus clock rising edges
`timescale 1ns/10ps
module ubsel_isa_pulse #(
  parameter LEN = 4
) (
  ref_clk,
  nrst,
  start,
  isa_rise,
  active
);
  input wire ref_clk;
  input wire nrst;
  input wire start;
  input wire isa_rise;
  output wire active;

  reg [3:0] cnt_q;
  reg [3:0] cnt_d;

  always @* begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = LEN[3:0];
    end else if (cnt_q != 4'h0 && isa_rise) begin
      cnt_d = cnt_q - 4'h1;
    end
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // partial isa period before the first edge makes the length approximate
  assign active = (cnt_q != 4'h0);
endmodule

/* rtl/ubsel_top.v */
// utility bus group select, encoded select, fast reset/a20 and media change bit
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "ubsel_consts.vh"

// Operation
// R01 - group select low decoder one, high two
// R02 - group select decoded combinationally from address
// R03 - clock chip latch strobe: two isa clocks
// R04 - group select high when idle or foreign
// R05 - group select high during reset
// R06 - writing bit0 one pulses cpu reset low
// R07 - bit0 must return zero before next pulse
// R08 - reset clears bit0, cpu reset high
// R09 - board ANDs soft and keyboard resets
// R10 - writing bit1 zero drives override low
// R11 - writing bit1 one drives override high
// R12 - override low after reset
// R13 - board ORs override, keyboard gate, reset
// R14 - floppy status read drives inverted media change; the code does so only with the floppy decode on and the IDE decode off
// R15 - primary/secondary status location from configuration
// R16 - encoded select code, high during reset
// R17 - data bit seven released outside those reads
module ubsel_top #(
  parameter RST_PULSE_CLKS = `UBSEL_RST_PULSE_CLKS,
  parameter ALE_HOLD_CLKS = `UBSEL_ALE_HOLD_CLKS
) (
  ref_clk,
  nrst,
  isa_bus_clock,
  sa,
  la,
  addr_valid,
  ior_n,
  iow_n,
  memr_n,
  memw_n,
  media_change_in,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  decoder_group_select_n,
  encoded_periph_select,
  soft_cpu_reset_n,
  addr20_override,
  sys_data_bit7_o,
  sys_data_bit7_oe_n
);
  input wire ref_clk;
  input wire nrst;
  input wire isa_bus_clock;
  input wire [16:0] sa;
  input wire [23:17] la;
  input wire addr_valid;
  input wire ior_n;
  input wire iow_n;
  input wire memr_n;
  input wire memw_n;
  input wire media_change_in;
  input wire [7:0] reg_addr;
  input wire [7:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [7:0] reg_rdata;
  output reg decoder_group_select_n;
  output reg [2:0] encoded_periph_select;
  output wire soft_cpu_reset_n;
  output wire addr20_override;
  output reg sys_data_bit7_o;
  output reg sys_data_bit7_oe_n;

  // register state
  reg rst_bit_q;
  reg a20_bit_q;
  reg [7:0] dec_en_q;
  reg [7:0] rdata_d;
  reg rd_pend_q;

  // isa clock and command edge tracking
  reg isa_clk_q;
  reg iow_n_q;
  reg reset_seen_q;
  reg floppy_present_q;

  wire isa_rise;
  wire iow_fall;
  wire rst_start;
  wire rst_busy;
  wire ale_start;
  wire ale_busy;

  wire io_space;
  wire mem_space;
  wire [9:0] io_addr;
  wire cmd_active;
  wire floppy_en;
  wire ide_en;
  wire [9:0] flp_base;
  wire [9:0] flp_stat;

  reg dec_hit;
  reg dec_group_n;
  reg [2:0] dec_code;

  wire wr_frac;
  wire wr_dec_en;

  assign isa_rise = isa_bus_clock & ~isa_clk_q;
  assign iow_fall = iow_n_q & ~iow_n;

  assign wr_frac = reg_wr && (reg_addr == `UBSEL_FRAC_OFFSET);
  assign wr_dec_en = reg_wr && (reg_addr == `UBSEL_DEC_EN_OFFSET);

  // only a zero-to-one change of bit0 fires, so a held one cannot retrigger
  assign rst_start = wr_frac && reg_wdata[`UBSEL_FRAC_RST_BIT] && !rst_bit_q; // R06 R07

  // io space is the low 64k with no upper address bits set
  assign io_space = (la == 7'h00) && (sa[16] == 1'b0);
  // bios window at 1F0000 to 1FFFFF, the top of the second megabyte
  assign mem_space = (la == 7'h0F) && (sa[16] == 1'b1);
  assign io_addr = sa[9:0];
  assign cmd_active = ~ior_n | ~iow_n;

  // a floppy strapped absent overrides the floppy decode enable
  assign floppy_en = dec_en_q[`UBSEL_EN_FLOPPY] & floppy_present_q;
  assign ide_en = dec_en_q[`UBSEL_EN_IDE];
  assign flp_base = dec_en_q[`UBSEL_EN_FLOPPY_SEC] ? `UBSEL_IO_FLP_SEC
                                                   : `UBSEL_IO_FLP_PRI; // R15
  assign flp_stat = dec_en_q[`UBSEL_EN_FLOPPY_SEC] ? `UBSEL_IO_FLP_STAT_SEC
                                                   : `UBSEL_IO_FLP_STAT_PRI; // R15

  // clock chip index write starts the latch strobe hold
  assign ale_start = iow_fall && addr_valid && io_space &&
                     (io_addr == `UBSEL_IO_RTC_IDX) &&
                     dec_en_q[`UBSEL_EN_RTC]; // R03

  ubsel_isa_pulse #(
    .LEN(RST_PULSE_CLKS)
  ) u_rst_pulse (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(rst_start),
    .isa_rise(isa_rise),
    .active(rst_busy)
  );

  ubsel_isa_pulse #(
    .LEN(ALE_HOLD_CLKS)
  ) u_ale_hold (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(ale_start),
    .isa_rise(isa_rise),
    .active(ale_busy)
  );

  assign soft_cpu_reset_n = ~rst_busy; // R06 R08 R09
  assign addr20_override = a20_bit_q; // R10 R11 R12

  // address decode, from the address lines, decode enables and memory strobes
  always @* begin
    dec_hit = 1'b0;
    dec_group_n = 1'b1;
    dec_code = `UBSEL_CODE_IDLE;
    if (addr_valid && io_space) begin // R02
      if (io_addr == `UBSEL_IO_RTC_DATA && dec_en_q[`UBSEL_EN_RTC]) begin
        dec_hit = 1'b1;
        dec_group_n = 1'b1; // R01
        dec_code = `UBSEL_CODE_RTC_DATA;
      end else if ((io_addr == `UBSEL_IO_KBD_DATA || io_addr == `UBSEL_IO_KBD_CMD) &&
                   dec_en_q[`UBSEL_EN_KBD]) begin
        dec_hit = 1'b1;
        dec_group_n = 1'b0; // R01
        dec_code = `UBSEL_CODE_KBD;
      end else if (io_addr[9:3] == flp_base[9:3] && io_addr != flp_stat && floppy_en) begin
        dec_hit = 1'b1;
        dec_group_n = 1'b0;
        dec_code = `UBSEL_CODE_FLOPPY;
      end else if (io_addr == flp_stat && ide_en) begin
        // shared status location belongs to the disk drive when it is resident
        dec_hit = 1'b1;
        dec_group_n = 1'b0;
        dec_code = `UBSEL_CODE_IDE;
      end else if (io_addr[9:3] == `UBSEL_IO_IDE_BASE >> 3 && ide_en) begin
        dec_hit = 1'b1;
        dec_group_n = 1'b0;
        dec_code = `UBSEL_CODE_IDE;
      end else if (io_addr[9:3] == `UBSEL_IO_SERA >> 3 && dec_en_q[`UBSEL_EN_SERA]) begin
        dec_hit = 1'b1;
        dec_group_n = 1'b0;
        dec_code = `UBSEL_CODE_SERA;
      end else if (io_addr[9:3] == `UBSEL_IO_SERB >> 3 && dec_en_q[`UBSEL_EN_SERB]) begin
        dec_hit = 1'b1;
        dec_group_n = 1'b0;
        dec_code = `UBSEL_CODE_SERB;
      end else if (io_addr[9:3] == `UBSEL_IO_PAR >> 3 && dec_en_q[`UBSEL_EN_PAR]) begin
        dec_hit = 1'b1;
        dec_group_n = 1'b0;
        dec_code = `UBSEL_CODE_PAR;
      end
    end else if (addr_valid && mem_space && (~memr_n | ~memw_n)) begin
      dec_hit = 1'b1;
      dec_group_n = 1'b1; // R01
      dec_code = 3'h0;
    end
  end

  // outputs follow the address with no register, as the decoders expect
  always @* begin
    if (!nrst) begin
      decoder_group_select_n = 1'b1; // R05
      encoded_periph_select = 3'h7; // R16
    end else if (ale_busy) begin
      decoder_group_select_n = 1'b0; // R03
      encoded_periph_select = `UBSEL_CODE_RTC_ALE; // R16
    end else if (dec_hit) begin
      decoder_group_select_n = dec_group_n; // R01 R02
      encoded_periph_select = dec_code; // R16
    end else begin
      decoder_group_select_n = 1'b1; // R04
      encoded_periph_select = `UBSEL_CODE_IDLE;
    end
  end

  // media change bit, driven only for reads of the selected status location
  always @(posedge ref_clk) begin
    if (!nrst) begin
      sys_data_bit7_o <= 1'b0;
      sys_data_bit7_oe_n <= 1'b1; // R17
    end else if (!ior_n && addr_valid && io_space && io_addr == flp_stat &&
                 floppy_en && !ide_en) begin
      sys_data_bit7_o <= ~media_change_in; // R14 R15
      sys_data_bit7_oe_n <= 1'b0; // R14
    end else begin
      sys_data_bit7_o <= 1'b0;
      sys_data_bit7_oe_n <= 1'b1; // R17
    end
  end

  // strap caught on the first edge after reset release
  always @(posedge ref_clk) begin
    if (!nrst) begin
      reset_seen_q <= 1'b0;
      floppy_present_q <= 1'b1;
    end else if (!reset_seen_q) begin
      reset_seen_q <= 1'b1;
      floppy_present_q <= media_change_in;
    end
  end

  // edge tracking for the isa clock and write command
  always @(posedge ref_clk) begin
    if (!nrst) begin
      isa_clk_q <= 1'b0;
      iow_n_q <= 1'b1;
    end else begin
      isa_clk_q <= isa_bus_clock;
      iow_n_q <= iow_n;
    end
  end

  // register writes
  always @(posedge ref_clk) begin
    if (!nrst) begin
      rst_bit_q <= 1'b0; // R08
      a20_bit_q <= 1'b0; // R12
      dec_en_q <= `UBSEL_DEC_EN_RESET;
    end else begin
      if (wr_frac) begin
        rst_bit_q <= reg_wdata[`UBSEL_FRAC_RST_BIT]; // R07
        a20_bit_q <= reg_wdata[`UBSEL_FRAC_A20_BIT]; // R10 R11
      end
      if (wr_dec_en) begin
        dec_en_q <= reg_wdata;
      end
    end
  end

  // read mux, answered in the cycle after the strobe
  always @* begin
    case (reg_addr)
      `UBSEL_FRAC_OFFSET: begin
        rdata_d = {6'h00, a20_bit_q, rst_bit_q};
      end
      `UBSEL_DEC_EN_OFFSET: begin
        rdata_d = dec_en_q;
      end
      `UBSEL_STATUS_OFFSET: begin
        rdata_d = {4'h0, ale_busy, decoder_group_select_n, rst_busy, floppy_present_q};
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      rd_pend_q <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      rd_pend_q <= reg_rd;
      // data lines rest at zero outside the answer cycle
      reg_rdata <= reg_rd ? rdata_d : 8'h00;
    end
  end

  // cmd_active and rd_pend_q are kept for status extension
  wire unused_ok;
  assign unused_ok = cmd_active & rd_pend_q;
endmodule

/* verif/ubsel_glue.sv */
// board glue model: cpu reset and a20 mask combining
`timescale 1ns/10ps
module ubsel_glue (
  input wire logic soft_cpu_reset_n,
  input wire logic addr20_override,
  input wire logic kbd_ctrl_reset_n,
  input wire logic kbd_addr20_gate,
  output wire logic cpu_reset_line,
  output wire logic cpu_addr20_mask_n
);
  assign cpu_reset_line = !(soft_cpu_reset_n && kbd_ctrl_reset_n);
  assign cpu_addr20_mask_n = addr20_override || kbd_addr20_gate || cpu_reset_line;
endmodule

/* verif/ubsel_assertions.sv */
// checker for the utility bus select block
`timescale 1ns/10ps
module ubsel_chk #(
  parameter RST_PULSE_CLKS = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic isa_bus_clock,
  input wire logic [16:0] sa,
  input wire logic addr_valid,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic media_change_in,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic decoder_group_select_n,
  input wire logic [2:0] encoded_periph_select,
  input wire logic soft_cpu_reset_n,
  input wire logic addr20_override,
  input wire logic sys_data_bit7_o,
  input wire logic sys_data_bit7_oe_n
);
  logic b0_q, rtc_q, isa_q;
  logic [7:0] n_q;
  logic [5:0] idle_q;
  logic [9:0] sa_q;
  wire w92 = reg_wr && reg_addr == 8'h92;
  // shadows of the stored bits, so checks do not depend on read back
  always @(posedge ref_clk) begin
    isa_q <= isa_bus_clock;
    sa_q <= sa[9:0];
    if (!nrst) begin
      b0_q <= 1'b0;
      rtc_q <= 1'b1;
      n_q <= 8'h00;
      idle_q <= 6'h00;
    end else begin
      if (w92)
        b0_q <= reg_wdata[0];
      if (reg_wr && reg_addr == 8'h4E)
        rtc_q <= reg_wdata[0];
      if (soft_cpu_reset_n)
        n_q <= 8'h00;
      else if (isa_bus_clock && !isa_q)
        n_q <= n_q + 8'h01;
      if (addr_valid || !iow_n)
        idle_q <= 6'h00;
      else if (idle_q != 6'h3F)
        idle_q <= idle_q + 6'h01;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  chk_pulse_start: assert property (w92 && reg_wdata[0] && !b0_q |=> !soft_cpu_reset_n)
    else $error("reset pulse missing");
  chk_no_repulse: assert property (w92 && b0_q && soft_cpu_reset_n |=> soft_cpu_reset_n)
    else $error("pulse without clearing");
  chk_pulse_max: assert property (!soft_cpu_reset_n |-> n_q <= RST_PULSE_CLKS)
    else $error("reset pulse too long");
  chk_pulse_min: assert property ($past(nrst) && $rose(soft_cpu_reset_n) |->
    n_q >= RST_PULSE_CLKS - 1)
    else $error("reset pulse too short");
  chk_a20_follow: assert property (w92 |=> addr20_override == $past(reg_wdata[1]))
    else $error("override wrong");
  chk_after_reset: assert property (!$past(nrst) |-> soft_cpu_reset_n && !addr20_override)
    else $error("outputs wrong after reset");
  chk_idle_high: assert property (idle_q >= 6'd20 |->
    decoder_group_select_n && encoded_periph_select == 3'h7)
    else $error("group select not idle");
  chk_rtc_strobe: assert property ($fell(iow_n) && addr_valid && sa == 17'h00070 && rtc_q |=>
    (!decoder_group_select_n && encoded_periph_select == 3'h0) [*4])
    else $error("strobe select wrong");
  chk_bit7_value: assert property (!sys_data_bit7_oe_n |->
    sys_data_bit7_o == !$past(media_change_in) && !$past(ior_n))
    else $error("bit7 value wrong");
  chk_bit7_addr: assert property (!sys_data_bit7_oe_n |-> sa_q == 10'h3F7 || sa_q == 10'h377)
    else $error("bit7 driven off status");
  chk_bit7_release: assert property (ior_n |=> sys_data_bit7_oe_n)
    else $error("bit7 not released");
endmodule
bind ubsel_top ubsel_chk #(.RST_PULSE_CLKS(RST_PULSE_CLKS)) u_chk (.*);

/* verif/tb_top.sv */
// testbench for the utility bus select block
`timescale 1ns/10ps
module tb_top;
  logic ref_clk = 1'b0;
  logic isa_clk = 1'b0;
  logic nrst = 1'b0;
  logic [16:0] sa = 17'h00060;
  logic [23:17] la = 7'h00;
  logic addr_valid = 1'b1;
  logic ior_n = 1'b1;
  logic iow_n = 1'b1;
  logic memr_n = 1'b1;
  logic media_chg = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic kbd_rst_n = 1'b1;
  logic kbd_gate = 1'b0;
  wire [7:0] rdata;
  wire [2:0] code;
  wire grp_n, soft_n, a20, b7, b7_oe_n, cpu_rst, cpu_addr20_mask_n_n;
  int n_mismatch = 0;
  int compares = 0;
  int n;
  logic [16:0] at [8] = '{17'h00060, 17'h00064, 17'h003F0, 17'h001F0,
    17'h003F8, 17'h002F8, 17'h00378, 17'h00071};
  logic [3:0] et [8] = '{4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
  initial forever #2 ref_clk = ~ref_clk;
  // isa clock at one eighth of the core clock keeps pulses short
  initial forever #16 isa_clk = ~isa_clk;
  ubsel_top dut (.ref_clk(ref_clk), .nrst(nrst), .isa_bus_clock(isa_clk), .sa(sa), .la(la),
    .addr_valid(addr_valid), .ior_n(ior_n), .iow_n(iow_n), .memr_n(memr_n), .memw_n(1'b1),
    .media_change_in(media_chg), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .decoder_group_select_n(grp_n),
    .encoded_periph_select(code), .soft_cpu_reset_n(soft_n), .addr20_override(a20),
    .sys_data_bit7_o(b7), .sys_data_bit7_oe_n(b7_oe_n));
  ubsel_glue glue (.soft_cpu_reset_n(soft_n), .addr20_override(a20),
    .kbd_ctrl_reset_n(kbd_rst_n), .kbd_addr20_gate(kbd_gate),
    .cpu_reset_line(cpu_rst), .cpu_addr20_mask_n(cpu_addr20_mask_n_n));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task adr(input logic [16:0] a, input logic v, input logic [3:0] e);
    @(posedge ref_clk);
    sa <= a;
    addr_valid <= v;
    #1 chk({4'h0, grp_n, code}, {4'h0, e});
  endtask
  // a released bit7 may hold anything, so only the enable is judged then
  task flp(input logic [16:0] a, input logic e);
    @(posedge ref_clk);
    sa <= a;
    addr_valid <= 1'b1;
    ior_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk({6'h00, b7_oe_n, b7 | b7_oe_n}, {6'h00, e, 1'b1});
    @(posedge ref_clk);
    ior_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk({7'h00, b7_oe_n}, 8'h01);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 chk({4'h0, grp_n, code}, 8'h0F);
    @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk({6'h00, a20, soft_n}, 8'h01);
    rd(8'h92, 8'h00);
    rd(8'h10, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
      adr(at[i], 1'b1, et[i]);
    // bios window read goes to the second decoder
    @(posedge ref_clk);
    la <= 7'h0F;
    memr_n <= 1'b0;
    adr(17'h10000, 1'b1, 4'h8);
    @(posedge ref_clk);
    la <= 7'h00;
    memr_n <= 1'b1;
    adr(17'h00060, 1'b0, 4'hF);
    $display("decode test done");
    wr(8'h92, 8'h02);
    #1 chk({6'h00, a20, cpu_addr20_mask_n_n}, 8'h03);
    rd(8'h92, 8'h02);
    wr(8'h92, 8'h00);
    #1 chk({6'h00, a20, cpu_addr20_mask_n_n}, 8'h00);
    $display("a20 test done");
    for (int k = 0; k < 2; k++) begin
      wr(8'h92, 8'h01);
      #1 chk({6'h00, soft_n, cpu_rst}, 8'h01);
      n = 0;
      while (!soft_n && n < 100) begin
        @(posedge ref_clk);
        #1 n++;
      end
      if (n >= 100) begin
        n_mismatch++;
        stop_test();
      end
      chk({7'h00, n >= 20 && n <= 36}, 8'h01);
      wr(8'h92, 8'h01);
      #1 chk({7'h00, soft_n}, 8'h01);
      wr(8'h92, 8'h00);
    end
    $display("soft reset test done");
    @(posedge ref_clk);
    sa <= 17'h00070;
    addr_valid <= 1'b1;
    iow_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk({4'h0, grp_n, code}, 8'h00);
    repeat (30) @(posedge ref_clk);
    iow_n <= 1'b1;
    addr_valid <= 1'b0;
    #1 chk({4'h0, grp_n, code}, 8'h0F);
    repeat (25) @(posedge ref_clk);
    $display("strobe test done");
    // reset in mid pulse with a decodable address on the bus
    wr(8'h92, 8'h03);
    @(posedge ref_clk);
    nrst <= 1'b0;
    sa <= 17'h00060;
    addr_valid <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk({4'h0, grp_n, code}, 8'h0F);
    @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk({6'h00, a20, soft_n}, 8'h01);
    rd(8'h92, 8'h00);
    $display("mid reset test done");
    media_chg <= 1'b0;
    wr(8'h4E, 8'h77);
    flp(17'h003F7, 1'b0);
    wr(8'h4E, 8'hF7);
    flp(17'h003F7, 1'b1);
    flp(17'h00377, 1'b0);
    $display("media change test done");
    stop_test();
  end
endmodule
